// ==== common/vrm_defines.svh ====
// How it works
// - horizontal counts run on pixel clock from line flyback
// - vertical counts are line flybacks from frame flyback
// - arm on enable, measure one frame from next flyback
// - keep smallest start and largest end per frame
// - every timing input has programmable polarity
// - horizontal start ten bits in bytes zero and one
// - horizontal end ten bits in bytes two and three
// - vertical start eleven bits in bytes four, five
// - vertical end upper three bits in byte six
// - result bytes read only, unused bits read zero
// - byte seven holds vertical end low byte
// - total frame lines eleven bits in bytes eight, nine
// - byte eight bit three flags line counter overflow
`ifndef VRM_DEFINES_SVH
`define VRM_DEFINES_SVH

// counter widths and limits
`define VRM_HW 10
`define VRM_VW 11
`define VRM_H_MAX 10'h3FF
`define VRM_V_MAX 11'h7FF
`define VRM_H_ZERO 10'h000
`define VRM_H_ONE 10'h001
`define VRM_V_ZERO 11'h000

// input pins
`define VRM_NPIN 5
`define VRM_PIN_HFLB 0
`define VRM_PIN_VFLB 1
`define VRM_PIN_RIN 2
`define VRM_PIN_GIN 3
`define VRM_PIN_BIN 4

// read-only result bytes
`define VRM_AW 4
`define VRM_OFS_HSTA_HI 4'h0
`define VRM_OFS_HSTA_LO 4'h1
`define VRM_OFS_HEND_HI 4'h2
`define VRM_OFS_HEND_LO 4'h3
`define VRM_OFS_VSTA_HI 4'h4
`define VRM_OFS_VSTA_LO 4'h5
`define VRM_OFS_VEND_HI 4'h6
`define VRM_OFS_VEND_LO 4'h7
`define VRM_OFS_VTOT_HI 4'h8
`define VRM_OFS_VTOT_LO 4'h9
`define VRM_OVER_BIT 3
`define VRM_RD_ZERO 8'h00

`endif

// ==== common/vrm_pkg.sv ====
`include "vrm_defines.svh"
package vrm_pkg;

   typedef enum logic [1:0] {VRM_IDLE, VRM_ARM, VRM_MEAS} vrm_state_e;

   typedef struct packed {
      logic [`VRM_HW-1:0] h_sta;
      logic [`VRM_HW-1:0] h_end;
      logic [`VRM_VW-1:0] v_sta;
      logic [`VRM_VW-1:0] v_end;
      logic [`VRM_VW-1:0] v_tot;
      logic over;
   } vrm_result_s;

   typedef struct packed {
      vrm_state_e st;
      logic en_prev;
      logic vid_prev;
      logic [`VRM_HW-1:0] hcnt;
      logic [`VRM_VW-1:0] vcnt;
      logic vcnt_ovf;
      logic seen_v;
      vrm_result_s work;
      vrm_result_s res;
      logic [7:0] rd_data;
   } vrm_state_s;

   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } vrm_sync_s;

endpackage : vrm_pkg

// ==== rtl/vrm_pin_sync.sv ====
`timescale 1ns/1ps
module vrm_pin_sync (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // pin and polarity
   input wire logic pin,
   input wire logic active_high,
   // conditioned level and edges
   output logic lvl,
   output logic rise,
   output logic fall
);

   vrm_pkg::vrm_sync_s q_reg;
   vrm_pkg::vrm_sync_s q_next;

   // polarity applied after the second flop
   // edges from the raw level: no false lead after reset or polarity change
   assign lvl = q_reg.s2 ~^ active_high;
   assign rise = (q_reg.s2 ^ q_reg.prev) & lvl;
   assign fall = (q_reg.s2 ^ q_reg.prev) & ~lvl;

   always_comb begin
      q_next = q_reg;
      q_next.s1 = pin;
      q_next.s2 = q_reg.s1;
      q_next.prev = q_reg.s2;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= '0;
      end else if (clk_en) begin
         q_reg <= q_next;
      end
   end

endmodule : vrm_pin_sync

// ==== rtl/vrm_top.sv ====
`timescale 1ns/1ps
`include "vrm_defines.svh"
module vrm_top (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // flyback and video pins
   input wire logic hflb_pin,
   input wire logic vflb_pin,
   input wire logic rin_pin,
   input wire logic gin_pin,
   input wire logic bin_pin,
   // control bits
   input wire logic measure_enable,
   input wire logic [`VRM_NPIN-1:0] pol_active_high,
   // result byte read port
   input wire logic [`VRM_AW-1:0] rd_addr,
   output logic [7:0] rd_data,
   // status
   output logic measure_busy
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release
   logic [1:0] rst_pipe;
   logic rst_n;
   vrm_pkg::vrm_state_s q_reg;
   vrm_pkg::vrm_state_s q_next;
   vrm_pkg::vrm_result_s work_init;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   ////////////////////////////////////////////////////////////////////////////
   // pin conditioning
   logic [`VRM_NPIN-1:0] pin_vec;
   logic [`VRM_NPIN-1:0] lvl;
   logic [`VRM_NPIN-1:0] rise;
   logic [`VRM_NPIN-1:0] fall;

   assign pin_vec = {bin_pin, gin_pin, rin_pin, vflb_pin, hflb_pin};

   for (genvar i = 0; i < `VRM_NPIN; i++) begin : g_pin
      vrm_pin_sync u_sync (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .clk_en(clk_en),
         .pin(pin_vec[i]),
         .active_high(pol_active_high[i]),
         .lvl(lvl[i]),
         .rise(rise[i]),
         .fall(fall[i])
      );
   end

   logic hlead;
   logic vlead;
   logic vid;
   logic vid_rise;
   logic vid_fall;
   logic en_rise;

   assign hlead = rise[`VRM_PIN_HFLB];
   assign vlead = rise[`VRM_PIN_VFLB];
   assign vid = lvl[`VRM_PIN_RIN] | lvl[`VRM_PIN_GIN] | lvl[`VRM_PIN_BIN];
   assign vid_rise = vid & ~q_reg.vid_prev;
   assign vid_fall = ~vid & q_reg.vid_prev;
   assign en_rise = measure_enable & ~q_reg.en_prev;

   ////////////////////////////////////////////////////////////////////////////
   // state

   function automatic logic [7:0] vrm_hi(input logic [15:0] v);
      return v[15:8];
   endfunction : vrm_hi

   always_comb begin
      work_init = '0;
      work_init.h_sta = `VRM_H_MAX;
      work_init.v_sta = `VRM_V_MAX;
   end

   always_comb begin
      q_next = q_reg;
      q_next.en_prev = measure_enable;
      q_next.vid_prev = vid;
      // lead cycle counts as one, so the count is the distance to the edge
      if (hlead) begin
         q_next.hcnt = `VRM_H_ONE;
      end else if (q_reg.hcnt != `VRM_H_MAX) begin
         q_next.hcnt = q_reg.hcnt + 1'b1;
      end
      case (q_reg.st)
         vrm_pkg::VRM_IDLE: begin
            if (en_rise) begin
               q_next.st = vrm_pkg::VRM_ARM;
            end
         end
         vrm_pkg::VRM_ARM: begin
            if (!measure_enable) begin
               q_next.st = vrm_pkg::VRM_IDLE;
            end else if (vlead) begin
               q_next.st = vrm_pkg::VRM_MEAS;
               q_next.vcnt = `VRM_V_ZERO;
               q_next.vcnt_ovf = 1'b0;
               q_next.seen_v = 1'b0;
               q_next.work = work_init;
            end
         end
         vrm_pkg::VRM_MEAS: begin
            if (!measure_enable) begin
               q_next.st = vrm_pkg::VRM_IDLE;
            end else if (vlead) begin
               // one full frame seen: publish results
               q_next.st = vrm_pkg::VRM_IDLE;
               q_next.res = q_reg.work;
               q_next.res.v_tot = q_reg.vcnt;
               q_next.res.over = q_reg.vcnt_ovf;
            end else begin
               if (hlead) begin
                  if (q_reg.vcnt == `VRM_V_MAX) begin
                     q_next.vcnt_ovf = 1'b1;
                  end else begin
                     q_next.vcnt = q_reg.vcnt + 1'b1;
                  end
               end
               if (vid_rise) begin
                  if (q_reg.hcnt < q_reg.work.h_sta) begin
                     q_next.work.h_sta = q_reg.hcnt;
                  end
                  if (!q_reg.seen_v) begin
                     q_next.seen_v = 1'b1;
                     q_next.work.v_sta = q_reg.vcnt;
                  end
                  q_next.work.v_end = q_reg.vcnt;
               end
               if (vid_fall && q_reg.hcnt > q_reg.work.h_end) begin
                  q_next.work.h_end = q_reg.hcnt;
               end
            end
         end
         default: begin
            q_next.st = vrm_pkg::VRM_IDLE;
         end
      endcase
      // read-only byte port, no write path exists
      case (rd_addr)
         `VRM_OFS_HSTA_HI: q_next.rd_data = vrm_hi(16'(q_reg.res.h_sta));
         `VRM_OFS_HSTA_LO: q_next.rd_data = q_reg.res.h_sta[7:0];
         `VRM_OFS_HEND_HI: q_next.rd_data = vrm_hi(16'(q_reg.res.h_end));
         `VRM_OFS_HEND_LO: q_next.rd_data = q_reg.res.h_end[7:0];
         `VRM_OFS_VSTA_HI: q_next.rd_data = vrm_hi(16'(q_reg.res.v_sta));
         `VRM_OFS_VSTA_LO: q_next.rd_data = q_reg.res.v_sta[7:0];
         `VRM_OFS_VEND_HI: q_next.rd_data = vrm_hi(16'(q_reg.res.v_end));
         `VRM_OFS_VEND_LO: q_next.rd_data = q_reg.res.v_end[7:0];
         `VRM_OFS_VTOT_HI: begin
            q_next.rd_data = vrm_hi(16'(q_reg.res.v_tot)) |
                             (8'(q_reg.res.over) << `VRM_OVER_BIT);
         end
         `VRM_OFS_VTOT_LO: q_next.rd_data = q_reg.res.v_tot[7:0];
         default: q_next.rd_data = `VRM_RD_ZERO;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= '0;
      end else if (clk_en) begin
         q_reg <= q_next;
      end
   end

   assign rd_data = q_reg.rd_data;
   assign measure_busy = (q_reg.st != vrm_pkg::VRM_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_armed;
      clk_en && q_reg.st == vrm_pkg::VRM_IDLE && en_rise;
   endsequence

   sequence s_frame_open;
      clk_en && q_reg.st == vrm_pkg::VRM_ARM && measure_enable && vlead;
   endsequence

   sequence s_frame_close;
      clk_en && q_reg.st == vrm_pkg::VRM_MEAS && measure_enable && vlead;
   endsequence

   a_arm_on_enable: assert property (
      s_armed |=> q_reg.st == vrm_pkg::VRM_ARM && measure_busy)
      else $error("enable did not arm measurement");

   a_frame_start: assert property (
      s_frame_open |=> q_reg.st == vrm_pkg::VRM_MEAS && q_reg.vcnt == `VRM_V_ZERO
                       && q_reg.work.h_sta == `VRM_H_MAX)
      else $error("measurement did not start at frame flyback");

   a_frame_commit: assert property (
      s_frame_close |=> q_reg.st == vrm_pkg::VRM_IDLE
                        && q_reg.res.v_tot == $past(q_reg.vcnt)
                        && q_reg.res.h_sta == $past(q_reg.work.h_sta))
      else $error("frame results not committed");

   a_over_flag: assert property (
      s_frame_close |=> q_reg.res.over == $past(q_reg.vcnt_ovf))
      else $error("overflow flag not reported");

   a_hcnt_restart: assert property (
      clk_en && hlead |=> q_reg.hcnt == `VRM_H_ONE ##1 (!$past(clk_en) || $past(hlead)
                                                      || q_reg.hcnt == `VRM_H_ONE + `VRM_H_ONE))
      else $error("pixel count not restarted at line flyback");

   a_line_count: assert property (
      clk_en && q_reg.st == vrm_pkg::VRM_MEAS && measure_enable && hlead && !vlead
      && q_reg.vcnt != `VRM_V_MAX |=> q_reg.vcnt == $past(q_reg.vcnt) + 1'b1)
      else $error("line flyback not counted");

   a_hsta_min: assert property (
      clk_en && q_reg.st == vrm_pkg::VRM_MEAS && measure_enable && !vlead && vid_rise
      |=> q_reg.work.h_sta <= $past(q_reg.hcnt))
      else $error("start not kept as minimum");

   a_hend_max: assert property (
      clk_en && q_reg.st == vrm_pkg::VRM_MEAS && measure_enable && !vlead && vid_fall
      |=> q_reg.work.h_end >= $past(q_reg.hcnt))
      else $error("end not kept as maximum");

   a_res_stable: assert property (
      q_reg.st != vrm_pkg::VRM_MEAS |=> $stable(q_reg.res))
      else $error("results changed outside commit");

   a_read_hsta: assert property (
      clk_en && rd_addr == `VRM_OFS_HSTA_HI
      |=> rd_data == {6'h00, $past(q_reg.res.h_sta[9:8])})
      else $error("horizontal start high byte wrong");

   a_read_vtot: assert property (
      clk_en && rd_addr == `VRM_OFS_VTOT_HI
      |=> rd_data == {4'h0, $past(q_reg.res.over), $past(q_reg.res.v_tot[10:8])})
      else $error("frame total high byte wrong");

   a_read_vend: assert property (
      clk_en && rd_addr == `VRM_OFS_VEND_LO |=> rd_data == $past(q_reg.res.v_end[7:0]))
      else $error("vertical end low byte wrong");

   a_unmapped_zero: assert property (
      clk_en && rd_addr > `VRM_OFS_VTOT_LO |=> rd_data == `VRM_RD_ZERO)
      else $error("unmapped byte not zero");

endmodule : vrm_top

// ==== test/video_raster_measurement_bench.sv ====
`timescale 1ns/1ps
`include "vrm_defines.svh"
module video_raster_measurement_bench;
   logic sys_clk, resetn, clk_en, measure_enable;
   logic hflb, vflb, rin, gin, bin;
   logic [4:0] pol;
   logic [`VRM_AW-1:0] rd_addr;
   logic [7:0] rd_data;
   logic measure_busy;
   logic [11:0] ll, nl, hon, hoff, von, voff;
   logic [9:0] e_hs, e_he;
   logic [10:0] e_vs, e_ve, e_vt;
   logic e_ov;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////////
   vrm_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .hflb_pin(hflb),
      .vflb_pin(vflb), .rin_pin(rin), .gin_pin(gin), .bin_pin(bin),
      .measure_enable(measure_enable), .pol_active_high(pol), .rd_addr(rd_addr),
      .rd_data(rd_data), .measure_busy(measure_busy));
   vrm_raster_gen gen_u (.sys_clk(sys_clk), .line_len(ll), .frame_lines(nl), .h_on(hon),
      .h_off(hoff), .v_on(von), .v_off(voff), .pol_active_high(pol), .hflb_pin(hflb),
      .vflb_pin(vflb), .rin_pin(rin), .gin_pin(gin), .bin_pin(bin));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 100000) begin
         fails++;
         $display("FAIL %0t run timed out", $time);
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic c, input string m);
      samples_checked++;
      if (c !== 1'b1) begin
         fails++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask : chk
   function automatic logic [7:0] exp_byte(input logic [3:0] a);
      case (a)
         4'h0: return {6'h00, e_hs[9:8]};
         4'h1: return e_hs[7:0];
         4'h2: return {6'h00, e_he[9:8]};
         4'h3: return e_he[7:0];
         4'h4: return {5'h00, e_vs[10:8]};
         4'h5: return e_vs[7:0];
         4'h6: return {5'h00, e_ve[10:8]};
         4'h7: return e_ve[7:0];
         4'h8: return {4'h0, e_ov, e_vt[10:8]};
         4'h9: return e_vt[7:0];
         default: return 8'h00;
      endcase
   endfunction : exp_byte
   // reads every byte index, results and unmapped alike
   task automatic check_all();
      for (int a = 0; a < 16; a++) begin
         @(negedge sys_clk);
         rd_addr = a[3:0];
         @(negedge sys_clk);
         chk(rd_data === exp_byte(a[3:0]), $sformatf("byte %0d read %0h", a, rd_data));
      end
   endtask : check_all
   task automatic setup(input logic [11:0] l, n, hs, he, vs, ve, input logic [4:0] p);
      @(negedge sys_clk);
      ll = l;
      nl = n;
      hon = hs;
      hoff = he;
      von = vs;
      voff = ve;
      pol = p;
   endtask : setup
   task automatic measure(input logic [11:0] l, n, hs, he, vs, ve, input logic [4:0] p);
      int k;
      int fr;
      setup(l, n, hs, he, vs, ve, p);
      fr = int'(l) * int'(n);
      e_hs = hs[9:0];
      e_he = he[9:0];
      e_vs = vs[10:0];
      e_ve = ve[10:0];
      e_ov = n > 12'h7FF;
      e_vt = e_ov ? 11'h7FF : n[10:0];
      measure_enable = 1'b1;
      @(negedge sys_clk);
      chk(measure_busy === 1'b1, "not armed");
      k = 0;
      // controller waits for completion, at most two frames plus 40 cycles
      while (measure_busy === 1'b1 && k < 2 * fr + 40) begin
         @(negedge sys_clk);
         k++;
      end
      chk(measure_busy === 1'b0 && k >= fr, "frame timing");
      // controller reads only after two full frames from enable
      while (k < 2 * fr) begin
         @(negedge sys_clk);
         k++;
      end
      check_all();
      repeat (20) @(negedge sys_clk);
      chk(measure_busy === 1'b0, "rearmed without new enable");
      measure_enable = 1'b0;
   endtask : measure
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      measure_enable = 1'b0;
      rd_addr = 4'h0;
      ll = 12'h040;
      nl = 12'h014;
      hon = 12'h00A;
      hoff = 12'h032;
      von = 12'h003;
      voff = 12'h00F;
      pol = 5'h1F;
      {e_hs, e_he, e_vs, e_ve, e_vt, e_ov} = '0;
      repeat (4) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (3) @(negedge sys_clk);
      check_all();
      measure(12'h040, 12'h014, 12'h00A, 12'h032, 12'h003, 12'h00F, 5'h1F);
      // low clock enable freezes the read byte
      rd_addr = 4'h1;
      @(negedge sys_clk);
      chk(rd_data === e_hs[7:0], "read before freeze");
      clk_en = 1'b0;
      rd_addr = 4'h3;
      repeat (3) @(negedge sys_clk);
      chk(rd_data === e_hs[7:0], "clock enable ignored");
      clk_en = 1'b1;
      @(negedge sys_clk);
      chk(rd_data === e_he[7:0], "read after freeze");
      // abort while armed leaves old results in place
      setup(12'h040, 12'h014, 12'h00C, 12'h028, 12'h005, 12'h009, 5'h15);
      measure_enable = 1'b1;
      repeat (5) @(negedge sys_clk);
      measure_enable = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk(measure_busy === 1'b0, "abort ignored");
      repeat (2600) @(negedge sys_clk);
      check_all();
      measure(12'h040, 12'h014, 12'h00C, 12'h028, 12'h005, 12'h009, 5'h15);
      measure(12'h00A, 12'h80C, 12'h004, 12'h009, 12'h003, 12'h00F, 5'h0A);
      final_report();
   end
endmodule : video_raster_measurement_bench

// ==== test/vrm_raster_gen.sv ====
`timescale 1ns/1ps
module vrm_raster_gen (
   // clock
   input wire logic sys_clk,
   // raster shape
   input wire logic [11:0] line_len,
   input wire logic [11:0] frame_lines,
   input wire logic [11:0] h_on,
   input wire logic [11:0] h_off,
   input wire logic [11:0] v_on,
   input wire logic [11:0] v_off,
   input wire logic [4:0] pol_active_high,
   // pins
   output logic hflb_pin,
   output logic vflb_pin,
   output logic rin_pin,
   output logic gin_pin,
   output logic bin_pin
);
   logic [11:0] pix_reg = 12'h000;
   logic [11:0] line_reg = 12'h000;
   logic [11:0] nrw;
   logic [11:0] col;
   logic vid;
   ////////////////////////////////////////////////////////////////////////////
   // free running raster, frame flyback mid-way through line zero
   always @(negedge sys_clk) begin
      if (pix_reg >= line_len - 12'h001) begin
         pix_reg <= 12'h000;
         line_reg <= (line_reg >= frame_lines - 12'h001) ? 12'h000 : line_reg + 12'h001;
      end else begin
         pix_reg <= pix_reg + 12'h001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // odd lines narrower, colour rotates per line
   assign nrw = {10'h000, line_reg[0], 1'b0};
   assign col = line_reg % 12'h003;
   assign vid = line_reg >= v_on && line_reg <= v_off && pix_reg >= h_on + nrw
                && pix_reg < h_off - nrw;
   assign hflb_pin = (pix_reg < 12'h003) ~^ pol_active_high[0];
   assign vflb_pin = (line_reg == 12'h000 && pix_reg >= line_len / 12'h002
                      && pix_reg < line_len / 12'h002 + 12'h002) ~^ pol_active_high[1];
   assign rin_pin = (vid && col == 12'h000) ~^ pol_active_high[2];
   assign gin_pin = (vid && col == 12'h001) ~^ pol_active_high[3];
   assign bin_pin = (vid && col == 12'h002) ~^ pol_active_high[4];
endmodule : vrm_raster_gen
